// [rtl/spio_pkg.sv]
/*
 shared pin i/o port: constants, register offsets, reset values, pin masks.
 assumes a 10 mhz system clock and a plain single-cycle register port.
*/
package spio_pkg;
    // sizes
    localparam int NPIN = 16; // port width, also remappable pin count
    localparam int NCN = 21; // change notify pins
    localparam int NCNX = 5; // change notify pins outside the port
    localparam int AW = 4; // register address width
    localparam int DW = 16; // register data width
    // register offsets
    localparam logic [AW-1:0] REG_DIR = 4'h0;
    localparam logic [AW-1:0] REG_LAT = 4'h1;
    localparam logic [AW-1:0] REG_PIN = 4'h2;
    localparam logic [AW-1:0] REG_ODC = 4'h3;
    localparam logic [AW-1:0] REG_ANCFG = 4'h4;
    localparam logic [AW-1:0] REG_CNEN_A = 4'h5;
    localparam logic [AW-1:0] REG_CNEN_B = 4'h6;
    localparam logic [AW-1:0] REG_PU_A = 4'h7;
    localparam logic [AW-1:0] REG_PU_B = 4'h8;
    localparam logic [AW-1:0] REG_MAP = 4'h9;
    localparam logic [AW-1:0] REG_LOCK = 4'ha;
    // reset values
    localparam logic [DW-1:0] RST_DIR = 16'hffff;
    localparam logic [DW-1:0] RST_ZERO = 16'h0000;
    localparam logic [DW-1:0] RST_ANCFG = 16'h0000;
    localparam logic [NCN-1:0] RST_CN = 21'h000000;
    localparam logic RST_LOCK = 1'b0;
    // variant masks: bonded bits, analog capable bits, open-drain capable bits
    localparam logic [DW-1:0] IMPL_MASK = 16'h7fff;
    localparam logic [DW-1:0] ANA_MASK = 16'h003f;
    localparam logic [DW-1:0] ODC_MASK = 16'hff00;
    // lock register: bit 0 sets the lock, this key clears it
    localparam int LOCK_BIT = 0;
    localparam logic [DW-1:0] UNLOCK_KEY = 16'h5a00;
    // clock
    localparam int CLK_PERIOD_NS = 100;

    // keep only bits that exist on this variant
    function automatic logic [DW-1:0] impl(input logic [DW-1:0] v);
        impl = v & IMPL_MASK;
    endfunction
endpackage

// [rtl/spio_cn.sv]
/*
 change notification detector for the shared pin i/o port.
 assumes levels arrive already sampled on clk_i.
*/
`timescale 1ns/1ns
module spio_cn
    import spio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // pin levels and enables
    input wire logic [NCN-1:0] level_i,
    input wire logic [NCN-1:0] en_i,
    // request to the processor
    output logic req_o
);
    logic [NCN-1:0] last_q; // level seen on the previous edge
    logic [NCN-1:0] diff; // enabled pins that moved

    // compare against the latched level; disabled pins never flag
    assign diff = (level_i ^ last_q) & en_i;

    // latch every level so enabling a pin later does not see a stale edge
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            last_q <= RST_CN;
        end else begin
            last_q <= level_i;
        end
    end

    // one-cycle request per change; this needs the clock, so a sleeping
    // system wakes on the second edge after the clock restarts
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            req_o <= 1'b0;
        end else begin
            req_o <= |diff;
        end
    end

    property p_cn_req;
        @(posedge clk_i) disable iff (!nrst_i)
        (|((level_i ^ last_q) & en_i)) |=> req_o;
    endproperty
    a_cn_req: assert property (p_cn_req) else $error("change not flagged");

    property p_cn_quiet;
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i == RST_CN) |=> !req_o;
    endproperty
    a_cn_quiet: assert property (p_cn_quiet) else $error("disabled pin flagged");
endmodule // spio_cn

// [rtl/spio_port.sv]
/*
 shared pin i/o port: direction, latch, pin read, peripheral ownership mux,
 open drain, analog read masking, routing map with lock, change notify.
 assumes pad inputs synchronous to clk_i and a one-cycle register port.
*/
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
module spio_port
    import spio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DW-1:0] rdata_o,
    // pads
    input wire logic [NPIN-1:0] pad_in_i,
    output logic [NPIN-1:0] pad_out_o,
    output logic [NPIN-1:0] pad_oe_o,
    output logic [NCN-1:0] pullup_o,
    // peripheral side, one lane per pin after routing
    input wire logic [NPIN-1:0] periph_en_i,
    input wire logic [NPIN-1:0] periph_drv_i,
    input wire logic [NPIN-1:0] periph_out_i,
    output logic [NPIN-1:0] periph_in_o,
    // change notification
    input wire logic [NCNX-1:0] cn_ext_i,
    output logic cn_irq_o
);
    // configuration state
    logic [DW-1:0] dir_q; // 1 = input
    logic [DW-1:0] lat_q; // output latch
    logic [DW-1:0] odc_q; // open-drain select
    logic [DW-1:0] ancfg_q; // 0 = analog, 1 = digital
    logic [NCN-1:0] cnen_q; // change notify enables
    logic [NCN-1:0] pu_q; // weak pull-up enables
    logic [NPIN-1:0] map_q; // 1 = peripheral routed to pin
    logic lock_q; // routing map locked
    // sampled inputs
    logic [DW-1:0] pin_q; // pad levels
    logic [NCNX-1:0] cnx_q; // extra change notify levels
    // combinational
    logic [NPIN-1:0] own_p; // peripheral owns the driver
    logic [NPIN-1:0] port_oe; // port wants to drive
    logic [NPIN-1:0] port_od; // port drives in open-drain style
    logic [DW-1:0] pin_rd; // pin register read value
    logic [DW-1:0] rdata_d; // read mux
    logic wr_dir, wr_lat, wr_odc, wr_an, wr_map, wr_lock; // write decode

    // strobe-qualified address match, shared by the write decodes
    function automatic logic hit(input logic stb, input logic [AW-1:0] a,
            input logic [AW-1:0] r);
        hit = stb && (a == r);
    endfunction

    // write decode, one register per strobe
    assign wr_dir = hit(wr_i, addr_i, REG_DIR);
    assign wr_lat = hit(wr_i, addr_i, REG_LAT) || hit(wr_i, addr_i, REG_PIN);
    assign wr_odc = hit(wr_i, addr_i, REG_ODC);
    assign wr_an = hit(wr_i, addr_i, REG_ANCFG);
    assign wr_map = hit(wr_i, addr_i, REG_MAP) && !lock_q;
    assign wr_lock = hit(wr_i, addr_i, REG_LOCK);

    // direction: all inputs after reset, missing bits forced to input
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            dir_q <= RST_DIR;
        end else if (wr_dir) begin
            dir_q <= wdata_i | ~IMPL_MASK;
        end
    end

    // output latch, reached through both the latch and pin offsets
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            lat_q <= RST_ZERO;
        end else if (wr_lat) begin
            lat_q <= impl(wdata_i);
        end
    end

    // open-drain select, only on capable pins
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            odc_q <= RST_ZERO;
        end else if (wr_odc) begin
            odc_q <= impl(wdata_i) & ODC_MASK;
        end
    end

    // analog config: zero means analog, so shared pins start analog
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ancfg_q <= RST_ANCFG;
        end else if (wr_an) begin
            ancfg_q <= wdata_i;
        end
    end

    // change notify enables, low 16 in one register, rest in the other
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnen_q <= RST_CN;
        end else if (hit(wr_i, addr_i, REG_CNEN_A)) begin
            cnen_q[DW-1:0] <= wdata_i;
        end else if (hit(wr_i, addr_i, REG_CNEN_B)) begin
            cnen_q[NCN-1:DW] <= wdata_i[NCNX-1:0];
        end
    end

    // weak pull-up enables, same split; software must clear them on
    // digital outputs, the hardware does not override that choice
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pu_q <= RST_CN;
        end else if (hit(wr_i, addr_i, REG_PU_A)) begin
            pu_q[DW-1:0] <= wdata_i;
        end else if (hit(wr_i, addr_i, REG_PU_B)) begin
            pu_q[NCN-1:DW] <= wdata_i[NCNX-1:0];
        end
    end

    // routing map: one bit per remappable pin, zero keeps the port bit
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            map_q <= RST_ZERO;
        end else if (wr_map) begin
            map_q <= wdata_i;
        end
    end

    // lock: set by bit 0, cleared only by the key, so a stray write
    // cannot open the map again
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            lock_q <= RST_LOCK;
        end else if (wr_lock) begin
            if (wdata_i == UNLOCK_KEY) begin
                lock_q <= 1'b0;
            end else if (wdata_i[LOCK_BIT]) begin
                lock_q <= 1'b1;
            end
        end
    end

    // pad sampling; reads see levels one cycle late, so with the registered pads software
    // leaves two cycles between a write and a read of the same port
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pin_q <= RST_ZERO;
            cnx_q <= RST_CN[NCNX-1:0];
        end else begin
            pin_q <= pad_in_i;
            cnx_q <= cn_ext_i;
        end
    end

    // ownership: an enabled, routed peripheral that drives takes the pin;
    // enabled but idle leaves it to the port
    assign own_p = periph_en_i & map_q & periph_drv_i & IMPL_MASK;
    assign port_oe = ~dir_q & IMPL_MASK & ~own_p;
    assign port_od = port_oe & odc_q;

    // output mux pair: data and enable, registered at the pads
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pad_out_o <= RST_ZERO;
            pad_oe_o <= RST_ZERO;
        end else begin
            pad_out_o <= (own_p & periph_out_i) | (~own_p & lat_q & ~port_od);
            pad_oe_o <= own_p | (port_oe & ~(port_od & lat_q));
        end
    end

    // peripheral input: blocked while the port itself drives the pin
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            periph_in_o <= RST_ZERO;
        end else begin
            periph_in_o <= pad_in_i & ~port_oe & IMPL_MASK;
        end
    end

    // pull-up pads
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pullup_o <= RST_CN;
        end else begin
            pullup_o <= pu_q;
        end
    end

    // pin read: analog-capable pins in analog mode read as low
    assign pin_rd = impl(pin_q) & ~(ANA_MASK & ~ancfg_q);

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = RST_ZERO;
        if (addr_i == REG_DIR) begin
            rdata_d = impl(dir_q);
        end else if (addr_i == REG_LAT) begin
            rdata_d = impl(lat_q);
        end else if (addr_i == REG_PIN) begin
            rdata_d = pin_rd;
        end else if (addr_i == REG_ODC) begin
            rdata_d = odc_q;
        end else if (addr_i == REG_ANCFG) begin
            rdata_d = ancfg_q;
        end else if (addr_i == REG_CNEN_A) begin
            rdata_d = cnen_q[DW-1:0];
        end else if (addr_i == REG_CNEN_B) begin
            rdata_d = {11'h000, cnen_q[NCN-1:DW]};
        end else if (addr_i == REG_PU_A) begin
            rdata_d = pu_q[DW-1:0];
        end else if (addr_i == REG_PU_B) begin
            rdata_d = {11'h000, pu_q[NCN-1:DW]};
        end else if (addr_i == REG_MAP) begin
            rdata_d = map_q;
        end else if (addr_i == REG_LOCK) begin
            rdata_d = {15'h0000, lock_q};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= RST_ZERO;
        end else if (rd_i) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= RST_ZERO;
        end
    end

    // change notify on port pins plus the extra inputs
    spio_cn u_cn (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .level_i({cnx_q, pin_q}),
        .en_i(cnen_q),
        .req_o(cn_irq_o)
    );

    // checks

    property p_reset_input;
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> (dir_q == RST_DIR) && (pad_oe_o == RST_ZERO);
    endproperty
    a_reset_input: assert property (p_reset_input) else $error("pins not inputs after reset");

    property p_port_drives;
        @(posedge clk_i) disable iff (!nrst_i)
        (!dir_q[0] && !own_p[0] && !odc_q[0]) |=> pad_oe_o[0] && (pad_out_o[0] == $past(lat_q[0]));
    endproperty
    a_port_drives: assert property (p_port_drives) else $error("port output not driven");

    property p_periph_owns;
        @(posedge clk_i) disable iff (!nrst_i)
        own_p[1] |=> pad_oe_o[1] && (pad_out_o[1] == $past(periph_out_i[1]));
    endproperty
    a_periph_owns: assert property (p_periph_owns) else $error("peripheral lost its pin");

    property p_idle_periph;
        @(posedge clk_i) disable iff (!nrst_i)
        (periph_en_i[2] && !periph_drv_i[2] && !dir_q[2] && !odc_q[2]) |=> pad_oe_o[2];
    endproperty
    a_idle_periph: assert property (p_idle_periph) else $error("idle peripheral blocked port");

    property p_no_loop;
        @(posedge clk_i) disable iff (!nrst_i)
        port_oe[3] |=> !periph_in_o[3];
    endproperty
    a_no_loop: assert property (p_no_loop) else $error("port output looped to peripheral");

    sequence s_lat_write;
        wr_i && (addr_i == REG_LAT);
    endsequence
    sequence s_lat_read;
        rd_i && (addr_i == REG_LAT) && !wr_i;
    endsequence
    property p_lat_rw;
        @(posedge clk_i) disable iff (!nrst_i)
        s_lat_write ##1 s_lat_read |=> rdata_o == impl($past(wdata_i, 2));
    endproperty
    a_lat_rw: assert property (p_lat_rw) else $error("latch readback wrong");

    property p_pin_write;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_i && (addr_i == REG_PIN)) |=> lat_q == impl($past(wdata_i));
    endproperty
    a_pin_write: assert property (p_pin_write) else $error("pin write missed latch");

    property p_analog_zero;
        @(posedge clk_i) disable iff (!nrst_i)
        (rd_i && (addr_i == REG_PIN) && !ancfg_q[0]) |=> !rdata_o[0];
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read high");

    property p_unimpl_zero;
        @(posedge clk_i) disable iff (!nrst_i)
        (rd_i && (addr_i <= REG_PIN)) |=> !rdata_o[15] && !pad_oe_o[15];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("missing bit not zero");

    property p_open_drain;
        @(posedge clk_i) disable iff (!nrst_i)
        (odc_q[8] && !dir_q[8] && !own_p[8]) |=> (pad_oe_o[8] == !$past(lat_q[8])) && !pad_out_o[8];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

    property p_map_lock;
        @(posedge clk_i) disable iff (!nrst_i)
        (lock_q && wr_i && (addr_i == REG_MAP)) |=> $stable(map_q);
    endproperty
    a_map_lock: assert property (p_map_lock) else $error("locked map changed");

    property p_lock_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (lock_q && wr_lock && (wdata_i != UNLOCK_KEY)) |=> lock_q;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("stray write opened lock");

    property p_read_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        !rd_i |=> (rdata_o == RST_ZERO);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outlived its cycle");

    property p_reset_cfg;
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> (ancfg_q == RST_ANCFG) && (lock_q == RST_LOCK)
            && (map_q == RST_ZERO);
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("config not reset");

    property p_dir_write;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_i && (addr_i == REG_DIR)) |=> dir_q[NPIN-1]
            && ((dir_q & IMPL_MASK) == ($past(wdata_i) & IMPL_MASK));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write wrong");

    property p_pu_write;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_i && (addr_i == REG_PU_A)) |=> ##1 (pullup_o[DW-1:0] == $past(wdata_i, 2));
    endproperty
    a_pu_write: assert property (p_pu_write) else $error("pull-up pads wrong");
endmodule // spio_port

// [testbench/spio_board.sv]
/*
 board model for the shared pin i/o port: resolves each pad level.
 assumes pad outputs registered on clk_i and a bench that steers the board drivers.
*/
`timescale 1ns/1ns
module spio_board
    import spio_pkg::*;
(
    // clock
    input wire logic clk_i,
    // device side of the pads
    input wire logic [NPIN-1:0] pad_out_i,
    input wire logic [NPIN-1:0] pad_oe_i,
    input wire logic [NPIN-1:0] pullup_i,
    // board drivers steered by the bench
    input wire logic [NPIN-1:0] drv_en_i,
    input wire logic [NPIN-1:0] drv_val_i,
    // resolved level seen by the device
    output logic [NPIN-1:0] pad_in_o
);
    logic [NPIN-1:0] last_q; // level of the previous cycle
    // remember each level so a floating line can wander away from it
    always_ff @(posedge clk_i) begin
        last_q <= pad_in_o;
    end
    // device driver first, then board, then pull-up; a floating line flips
    // every cycle, so no stale value can pass for a real one
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pad_oe_i[i]) begin
                pad_in_o[i] = pad_out_i[i];
            end else if (drv_en_i[i]) begin
                pad_in_o[i] = drv_val_i[i];
            end else if (pullup_i[i]) begin
                pad_in_o[i] = 1'b1;
            end else begin
                pad_in_o[i] = ~last_q[i];
            end
        end
    end
endmodule // spio_board

// [testbench/tb.sv]
/*
 self-checking bench for the shared pin i/o port, one task per scenario.
 assumes the board model beside it and the register map of the package.
*/
`timescale 1ns/1ns
module tb;
    import spio_pkg::*;
    // design inputs and board steering
    logic clk_i, nrst_i, wr_i, rd_i;
    logic [AW-1:0] addr_i;
    logic [DW-1:0] wdata_i;
    logic [NPIN-1:0] periph_en_i, periph_drv_i, periph_out_i, drv_en, drv_val;
    logic [NCNX-1:0] cn_ext_i;
    // design outputs
    logic [DW-1:0] rdata_o;
    logic [NPIN-1:0] pad_in_i, pad_out_o, pad_oe_o, periph_in_o;
    logic [NCN-1:0] pullup_o;
    logic cn_irq_o;
    // bookkeeping
    int fails, n_tests, base;
    int irq_n = 0; // request cycles seen, written by the counter only

    spio_port dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pad_in_i(pad_in_i),
        .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pullup_o(pullup_o),
        .periph_en_i(periph_en_i), .periph_drv_i(periph_drv_i),
        .periph_out_i(periph_out_i), .periph_in_o(periph_in_o),
        .cn_ext_i(cn_ext_i), .cn_irq_o(cn_irq_o));
    spio_board board (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pullup_i(pullup_o[NPIN-1:0]), .drv_en_i(drv_en), .drv_val_i(drv_val),
        .pad_in_o(pad_in_i));

    // 10 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // counts request cycles; a pulse longer than one cycle counts once for each cycle it stays high
    always @(posedge clk_i) begin
        if (cn_irq_o === 1'b1) begin
            irq_n <= irq_n + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(32'(rdata_o), 32'(e));
    endtask
    // lets register, pad and sampling latency run out; covers the read gap too
    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        chk(32'(pad_oe_o), 32'h0);
        rchk(REG_DIR, RST_DIR & IMPL_MASK);
        rchk(REG_ANCFG, 16'h0000);
        @(posedge clk_i);
        #1 chk(32'(rdata_o), 32'h0);
        wr(4'hb, 16'hffff);
        rchk(4'hb, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_latch();
        wr(REG_LAT, 16'ha5a5);
        rchk(REG_LAT, 16'h25a5);
        wr(REG_PIN, 16'h1234);
        rchk(REG_LAT, 16'h1234);
        rchk(REG_DIR, 16'h7fff);
        chk(32'(pad_oe_o), 32'h0);
        $display("test latch done");
    endtask
    task automatic t_output();
        wr(REG_ANCFG, 16'hffff);
        wr(REG_DIR, 16'h0000);
        wr(REG_LAT, 16'h00ff);
        settle();
        chk(32'(pad_oe_o), 32'h7fff);
        chk(32'(pad_out_o & IMPL_MASK), 32'h00ff);
        rchk(REG_PIN, 16'h00ff);
        drv_val <= 16'h5555;
        wr(REG_DIR, 16'h00ff);
        settle();
        chk(32'(pad_oe_o), 32'h7f00);
        rchk(REG_PIN, 16'h0055);
        $display("test output done");
    endtask
    task automatic t_analog();
        drv_val <= 16'hffff;
        wr(REG_DIR, 16'hffff);
        wr(REG_ANCFG, 16'h0000);
        settle();
        rchk(REG_PIN, 16'h7fc0);
        rchk(REG_LAT, 16'h00ff);
        wr(REG_ANCFG, 16'hffff);
        settle();
        rchk(REG_PIN, 16'h7fff);
        $display("test analog done");
    endtask
    task automatic t_periph();
        wr(REG_DIR, 16'h0000);
        wr(REG_LAT, 16'hff00);
        wr(REG_MAP, 16'h00ff);
        periph_en_i <= 16'hffff;
        periph_drv_i <= 16'h00ff;
        periph_out_i <= 16'h00aa;
        settle();
        chk(32'(pad_oe_o), 32'h7fff);
        chk(32'(pad_out_o & IMPL_MASK), 32'h7faa);
        chk(32'(periph_in_o & 16'h7f00), 32'h0);
        chk(32'(periph_in_o & 16'h00ff), 32'h00aa);
        rchk(REG_PIN, 16'h7faa);
        wr(REG_LOCK, 16'h0001);
        rchk(REG_LOCK, 16'h0001);
        wr(REG_LOCK, 16'h0000);
        wr(REG_MAP, 16'h0000);
        settle();
        chk(32'(pad_out_o & IMPL_MASK), 32'h7faa);
        wr(REG_LOCK, UNLOCK_KEY);
        wr(REG_MAP, 16'h0000);
        settle();
        chk(32'(pad_out_o & IMPL_MASK), 32'h7f00);
        periph_en_i <= 16'h0000;
        $display("test peripheral done");
    endtask
    task automatic t_odrain();
        wr(REG_ODC, 16'hffff);
        wr(REG_LAT, 16'h0f55);
        settle();
        chk(32'(pad_oe_o), 32'h70ff);
        chk(32'(pad_out_o & 16'h70ff), 32'h0055);
        rchk(REG_ODC, 16'h7f00);
        wr(REG_ODC, 16'h0000);
        $display("test open drain done");
    endtask
    // second reset in mid-run: configuration falls back to all inputs
    task automatic t_rst_mid();
        wr(REG_LOCK, 16'h0001);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1 chk(32'(pad_oe_o), 32'h0);
        rchk(REG_DIR, RST_DIR & IMPL_MASK);
        rchk(REG_ANCFG, RST_ANCFG);
        rchk(REG_LAT, 16'h0000);
        rchk(REG_LOCK, 16'h0000);
        wr(REG_ANCFG, 16'hffff);
        $display("test mid reset done");
    endtask
    // low board pins released so only the pull-ups can lift them
    task automatic t_pullup();
        drv_val <= 16'h0000;
        drv_en <= 16'hff00;
        wr(REG_DIR, 16'hffff);
        wr(REG_PU_A, 16'h00ff);
        wr(REG_PU_B, 16'hffff);
        settle();
        chk(32'(pullup_o), 32'h1f00ff);
        rchk(REG_PU_B, 16'h001f);
        rchk(REG_PIN, 16'h00ff);
        drv_en <= 16'hffff;
        $display("test pull-up done");
    endtask
    task automatic t_cn();
        drv_val <= 16'h0000;
        wr(REG_CNEN_A, 16'h0100);
        wr(REG_CNEN_B, 16'h0001);
        settle();
        rchk(REG_CNEN_B, 16'h0001);
        base = irq_n;
        drv_val[8] <= 1'b1;
        settle();
        chk(32'(irq_n - base), 32'd1);
        drv_val[9] <= 1'b1;
        settle();
        chk(32'(irq_n - base), 32'd1);
        cn_ext_i[0] <= 1'b1;
        settle();
        chk(32'(irq_n - base), 32'd2);
        cn_ext_i[4] <= 1'b1;
        drv_val[8] <= 1'b0;
        @(posedge clk_i);
        drv_val[8] <= 1'b1;
        settle();
        chk(32'(irq_n - base), 32'd4);
        $display("test change notify done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence: everything idle at time zero, reset for five cycles
    initial begin
        fails = 0;
        n_tests = 0;
        nrst_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        periph_en_i = 16'h0000;
        periph_drv_i = 16'h0000;
        periph_out_i = 16'h0000;
        drv_en = 16'hffff;
        drv_val = 16'h0000;
        cn_ext_i = 5'h00;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1;
        t_reset();
        t_latch();
        t_output();
        t_analog();
        t_periph();
        t_odrain();
        t_rst_mid();
        t_pullup();
        t_cn();
        wrap_up();
    end
    // watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        #2000000;
        fails++;
        $display("ERROR at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule // tb
